// ===== bench/lane_phy_control_regs_tb_top.sv
// Self-checking bench for the lane control register block
`timescale 1ns/10ps
`default_nettype none
`include "lpcr_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module lane_phy_control_regs_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic scl = 1'b1;
   logic md = 1'b0;
   logic [1:0] lane_mode = 2'h0;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   wire logic sda_o, sda_oe, stop_st, ulp_st, sda_line;
   wire logic [9:0] outs;
   always #50 clk = ~clk;
   // Open drain: either party pulls low, otherwise pulled up
   assign sda_line = ~((sda_oe & ~sda_o) | md);
   lpcr_lane_model lane (.clk(clk), .mode(lane_mode), .stop_state(stop_st), .ulp_active(ulp_st));
   lpcr_regs dut (.clk(clk), .reset_n(reset_n), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
      .clock_lane_stop_state(stop_st), .clock_lane_ulp_active(ulp_st),
      .clock_lane_protocol_select(outs[9]), .clock_lane_hs_termination_enable(outs[8]),
      .clock_lane_hs_receiver_enable(outs[7]), .clock_lane_hs_receiver_wakeup(outs[6]),
      .data_lane_protocol_select(outs[5]), .data_lane_hs_termination_enable(outs[4]),
      .data_lane_hs_receiver_enable(outs[3]), .data_lane_hs_receiver_wakeup(outs[2]),
      .data_lane_enable(outs[1]), .data_lane_pn_swap(outs[0]));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // 800 ns bit; low for six clocks so the device's own drive settles before SCL rises
   task automatic bitx(input logic b, output logic r);
      tick(1);
      md <= ~b;
      tick(5);
      scl <= 1'b1;
      tick(1);
      r = sda_line;
      tick(1);
      scl <= 1'b0;
   endtask
   task automatic start;
      tick(2);
      md <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(8);
      md <= 1'b1;
      tick(8);
      scl <= 1'b0;
   endtask
   task automatic stop;
      tick(2);
      md <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(8);
      md <= 1'b0;
      tick(8);
   endtask
   task automatic xfer(input lpcr_pkg::lpcr_byte_t d, input logic last, output lpcr_pkg::lpcr_byte_t r,
      output logic a);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(d[i], b);
         r[i] = b;
      end
      bitx(last, a);
   endtask
   task automatic wr(input lpcr_pkg::lpcr_byte_t p, input lpcr_pkg::lpcr_byte_t v);
      lpcr_pkg::lpcr_byte_t r;
      logic a;
      start;
      xfer({`LPCR_DEV_ADDR, 1'b0}, 1'b1, r, a);
      `CHK(a, 1'b0)
      xfer(p, 1'b1, r, a);
      xfer(v, 1'b1, r, a);
      `CHK(a, 1'b0)
      stop;
      tick(8);
   endtask
   task automatic rd(input lpcr_pkg::lpcr_byte_t p, input lpcr_pkg::lpcr_byte_t e);
      lpcr_pkg::lpcr_byte_t r;
      logic a;
      start;
      xfer({`LPCR_DEV_ADDR, 1'b0}, 1'b1, r, a);
      xfer(p, 1'b1, r, a);
      start;
      xfer({`LPCR_DEV_ADDR, 1'b1}, 1'b1, r, a);
      `CHK(a, 1'b0)
      xfer(8'hff, 1'b1, r, a);
      `CHK(r, e)
      stop;
   endtask
   task automatic t_reset;
      `CHK(outs, 10'h001)
      rd(`LPCR_OFF_CLK_STATUS, 8'h00);
      rd(`LPCR_OFF_CLK_MODE, 8'h00);
      rd(`LPCR_OFF_DL_GEN, 8'h00);
      rd(`LPCR_OFF_DL_MODE, 8'h00);
   endtask
   task automatic t_mode;
      wr(`LPCR_OFF_CLK_MODE, 8'hfd);
      wr(`LPCR_OFF_DL_MODE, 8'hfe);
      `CHK(outs, 10'h1dd)
      rd(`LPCR_OFF_CLK_MODE, 8'h1c);
      rd(`LPCR_OFF_DL_MODE, 8'h0e);
      wr(`LPCR_OFF_CLK_MODE, 8'h1e);
      wr(`LPCR_OFF_DL_MODE, 8'h0f);
      `CHK(outs, 10'h221)
      rd(`LPCR_OFF_CLK_MODE, 8'h1e);
   endtask
   task automatic t_dlgen;
      wr(`LPCR_OFF_DL_GEN, 8'hff);
      `CHK(outs[1:0], 2'b10)
      rd(`LPCR_OFF_DL_GEN, 8'h03);
      wr(`LPCR_OFF_DL_GEN, 8'h01);
      `CHK(outs[1:0], 2'b11)
      wr(`LPCR_OFF_DL_GEN, 8'h02);
      `CHK(outs[1:0], 2'b00)
   endtask
   task automatic t_status;
      lane_mode <= 2'h1;
      rd(`LPCR_OFF_CLK_STATUS, 8'h01);
      lane_mode <= 2'h2;
      rd(`LPCR_OFF_CLK_STATUS, 8'h02);
      wr(`LPCR_OFF_CLK_STATUS, 8'hfc);
      rd(`LPCR_OFF_CLK_STATUS, 8'h02);
      lane_mode <= 2'h0;
      rd(`LPCR_OFF_CLK_STATUS, 8'h00);
      lane_mode <= 2'h1;
      wr(`LPCR_OFF_CLK_MODE, 8'h1c);
      rd(`LPCR_OFF_CLK_STATUS, 8'h00);
   endtask
   // A foreign address must be left unanswered
   task automatic t_refuse;
      lpcr_pkg::lpcr_byte_t r;
      logic a;
      start;
      xfer({`LPCR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
      `CHK(a, 1'b1)
      stop;
   endtask
   // Pointer moves on after every byte, written or read
   task automatic t_burst;
      lpcr_pkg::lpcr_byte_t r;
      logic a;
      start;
      xfer({`LPCR_DEV_ADDR, 1'b0}, 1'b1, r, a);
      xfer(`LPCR_OFF_DL_GEN, 1'b1, r, a);
      xfer(8'h01, 1'b1, r, a);
      xfer(8'h0e, 1'b1, r, a);
      `CHK(a, 1'b0)
      stop;
      tick(8);
      `CHK(outs, 10'h1df)
      start;
      xfer({`LPCR_DEV_ADDR, 1'b0}, 1'b1, r, a);
      xfer(`LPCR_OFF_DL_GEN, 1'b1, r, a);
      start;
      xfer({`LPCR_DEV_ADDR, 1'b1}, 1'b1, r, a);
      xfer(8'hff, 1'b0, r, a);
      `CHK(r, 8'h01)
      xfer(8'hff, 1'b1, r, a);
      `CHK(r, 8'h0e)
      stop;
   endtask
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         n_fail++;
         final_report;
      end
   end
   initial
   begin
      tick(3);
      reset_n <= 1'b1;
      tick(4);
      t_reset;
      t_mode;
      t_dlgen;
      t_status;
      t_refuse;
      t_burst;
      final_report;
   end
endmodule
`default_nettype wire

// ===== bench/lpcr_lane_model.sv
// Sensor-side clock lane state model: high-speed, stop or ultra-low-power
`timescale 1ns/10ps
`default_nettype none
module lpcr_lane_model (
   input wire logic clk,
   input wire logic [1:0] mode,
   output logic stop_state,
   output logic ulp_active
);
   // One state at a time, so ULP never shows together with stop
   always_ff @(posedge clk)
   begin
      stop_state <= (mode == 2'h1);
      ulp_active <= (mode == 2'h2);
   end
endmodule
`default_nettype wire

// ===== hw/lpcr_regs.sv
// Lane control and status registers behind the serial control port
`timescale 1ns/10ps
`default_nettype none
`include "lpcr_consts.svh"
// Notes on behaviour
// RL1 - Protocol select: 0 CCP, 1 CSI; clock bit 1, data bit 0; resets CCP
// RL2 - Termination enable, clock bit 4, data bit 3; only acts in CCP
// RL3 - Receiver enable, clock bit 3, data bit 2; only acts in CCP
// RL4 - Wake-up, clock bit 2, data bit 1; clear keeps receiver low power; CCP only
// RL5 - Clock status bit 1 reads 1 once the lane sits in ultra-low-power; CSI only
// RL6 - Clock status bit 0 reads stop state; CSI only; resets to 0
// RL7 - Data lane enable is general control bit 0, reset 0 so disabled
// RL8 - General control bit 1: 0 swaps P and N pins, 1 leaves them
// RL9 - Reserved bits read zero, writes to them are dropped
// RL10 - Writes to the clock status register change nothing
module lpcr_regs #(
   parameter logic [6:0] DEV_ADDR = `LPCR_DEV_ADDR
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic clock_lane_stop_state,
   input wire logic clock_lane_ulp_active,
   output logic clock_lane_protocol_select,
   output logic clock_lane_hs_termination_enable,
   output logic clock_lane_hs_receiver_enable,
   output logic clock_lane_hs_receiver_wakeup,
   output logic data_lane_protocol_select,
   output logic data_lane_hs_termination_enable,
   output logic data_lane_hs_receiver_enable,
   output logic data_lane_hs_receiver_wakeup,
   output logic data_lane_enable,
   output logic data_lane_pn_swap
);
   logic [3:0] sync_q;
   logic scl_f, sda_f, stop_f, ulp_f;
   logic scl_p_q, sda_p_q;
   lpcr_pkg::lpcr_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   lpcr_pkg::lpcr_byte_t sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
   lpcr_pkg::lpcr_byte_t clk_mode_q, dl_gen_q, dl_mode_q;
   logic oe_q, oe_d, rw_q, rw_d, first_q, first_d, nack_q, nack_d, wr_fire;
   logic [9:0] out_q;

   // Pins and lane status come from outside the clock domain
   lpcr_sync #(.W(4), .RST(4'h3)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({clock_lane_ulp_active, clock_lane_stop_state, sda_i, scl}),
      .q(sync_q)
   );
   assign ulp_f = sync_q[3];
   assign stop_f = sync_q[2];
   assign sda_f = sync_q[1];
   assign scl_f = sync_q[0];

   wire scl_rise = scl_f & ~scl_p_q;
   wire scl_fall = ~scl_f & scl_p_q;
   wire start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
   wire stop_ev = scl_f & scl_p_q & ~sda_p_q & sda_f;
   wire byte_done = (cnt_q == `LPCR_BITS_PER_BYTE);
   // Ninth clock of a read byte belongs to the master
   wire ack_phase = (cnt_q == `LPCR_TX_ACK_CNT);
   wire clk_csi = clk_mode_q[`LPCR_CLK_PROTO_BIT];
   wire dl_csi = dl_mode_q[`LPCR_DL_PROTO_BIT];
   // Status only means something in CSI, so it is masked in CCP
   wire [7:0] status_v = {6'h00, ulp_f & clk_csi, stop_f & clk_csi}; // RL5 RL6

   function automatic lpcr_pkg::lpcr_byte_t reg_read(input lpcr_pkg::lpcr_byte_t a);
      case (a)
         `LPCR_OFF_CLK_STATUS: reg_read = status_v;
         `LPCR_OFF_CLK_MODE: reg_read = clk_mode_q; // RL9
         `LPCR_OFF_DL_GEN: reg_read = dl_gen_q;
         `LPCR_OFF_DL_MODE: reg_read = dl_mode_q;
         default: reg_read = 8'h00;
      endcase
   endfunction

   wire [7:0] rd_ptr = reg_read(ptr_q);
   // Status offset has no write strobe at all
   wire wr_clk_mode = wr_fire && (ptr_q == `LPCR_OFF_CLK_MODE); // RL10
   wire wr_dl_gen = wr_fire && (ptr_q == `LPCR_OFF_DL_GEN);
   wire wr_dl_mode = wr_fire && (ptr_q == `LPCR_OFF_DL_MODE);

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      rw_d = rw_q;
      first_d = first_q;
      nack_d = nack_q;
      wr_fire = 1'b0;
      if (stop_ev)
      begin
         st_d = lpcr_pkg::LPCR_IDLE;
         oe_d = 1'b0;
      end
      else if (start_ev)
      begin
         st_d = lpcr_pkg::LPCR_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
         first_d = 1'b1;
      end
      else
      begin
         case (st_q)
            lpcr_pkg::LPCR_ADDR, lpcr_pkg::LPCR_RX:
            begin
               if (scl_rise)
               begin
                  sh_d = {sh_q[6:0], sda_f};
                  cnt_d = cnt_q + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  oe_d = 1'b1;
                  if (st_q == lpcr_pkg::LPCR_RX)
                  begin
                     st_d = lpcr_pkg::LPCR_ACK_RX;
                     first_d = 1'b0;
                     wr_fire = ~first_q;
                     ptr_d = first_q ? sh_q : ptr_q + 8'h01;
                  end
                  else if (sh_q[7:1] == DEV_ADDR)
                  begin
                     rw_d = sh_q[0];
                     st_d = lpcr_pkg::LPCR_ACK_ADDR;
                  end
                  else
                  begin
                     oe_d = 1'b0;
                     st_d = lpcr_pkg::LPCR_IDLE;
                  end
               end
            end
            lpcr_pkg::LPCR_ACK_ADDR, lpcr_pkg::LPCR_ACK_RX:
            begin
               if (scl_rise)
                  nack_d = 1'b0;
               if (scl_fall)
               begin
                  cnt_d = 4'h0;
                  if (rw_q && st_q == lpcr_pkg::LPCR_ACK_ADDR)
                  begin
                     tx_d = rd_ptr;
                     oe_d = ~rd_ptr[7];
                     st_d = lpcr_pkg::LPCR_TX;
                  end
                  else
                  begin
                     oe_d = 1'b0;
                     st_d = lpcr_pkg::LPCR_RX;
                  end
               end
            end
            lpcr_pkg::LPCR_TX:
            begin
               if (scl_rise && ack_phase)
                  nack_d = sda_f;
               else if (scl_rise)
                  cnt_d = cnt_q + 4'h1;
               else if (scl_fall && ack_phase)
               begin
                  // Master acknowledge phase has just ended
                  cnt_d = 4'h0;
                  if (nack_q)
                  begin
                     oe_d = 1'b0;
                     st_d = lpcr_pkg::LPCR_IDLE;
                  end
                  else
                  begin
                     tx_d = reg_read(ptr_q);
                     oe_d = ~rd_ptr[7];
                  end
               end
               else if (scl_fall && byte_done)
               begin
                  // All eight bits are out; let go so the master can answer
                  oe_d = 1'b0;
                  ptr_d = ptr_q + 8'h01;
                  cnt_d = `LPCR_TX_ACK_CNT;
               end
               else if (scl_fall)
               begin
                  tx_d = {tx_q[6:0], 1'b0};
                  oe_d = ~tx_q[6];
               end
            end
            lpcr_pkg::LPCR_IDLE:
               oe_d = 1'b0;
            default:
            begin
               st_d = lpcr_pkg::LPCR_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= lpcr_pkg::LPCR_IDLE;
         {cnt_q, sh_q, tx_q, ptr_q} <= 28'h0000000;
         {oe_q, rw_q, first_q, nack_q} <= 4'h0;
         {scl_p_q, sda_p_q} <= 2'h3;
      end
      else
      begin
         st_q <= st_d;
         {cnt_q, sh_q, tx_q, ptr_q} <= {cnt_d, sh_d, tx_d, ptr_d};
         {oe_q, rw_q, first_q, nack_q} <= {oe_d, rw_d, first_d, nack_d};
         {scl_p_q, sda_p_q} <= {scl_f, sda_f};
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         clk_mode_q <= `LPCR_CTRL_RESET; // RL1
         dl_gen_q <= `LPCR_CTRL_RESET; // RL7
         dl_mode_q <= `LPCR_CTRL_RESET;
      end
      else
      begin
         if (wr_clk_mode)
            clk_mode_q <= sh_q & `LPCR_CLK_MODE_MASK; // RL9
         if (wr_dl_gen)
            dl_gen_q <= sh_q & `LPCR_DL_GEN_MASK;
         if (wr_dl_mode)
            dl_mode_q <= sh_q & `LPCR_DL_MODE_MASK;
      end
   end

   // Receiver controls only reach the pads in CCP; CSI handles the lane itself
   wire [9:0] out_d = {
      clk_csi, // RL1
      clk_mode_q[`LPCR_CLK_TERM_BIT] & ~clk_csi, // RL2
      clk_mode_q[`LPCR_CLK_RXEN_BIT] & ~clk_csi, // RL3
      clk_mode_q[`LPCR_CLK_WAKE_BIT] & ~clk_csi, // RL4
      dl_csi,
      dl_mode_q[`LPCR_DL_TERM_BIT] & ~dl_csi,
      dl_mode_q[`LPCR_DL_RXEN_BIT] & ~dl_csi,
      dl_mode_q[`LPCR_DL_WAKE_BIT] & ~dl_csi,
      dl_gen_q[`LPCR_DL_EN_BIT], // RL7
      ~dl_gen_q[`LPCR_DL_SWAP_N_BIT] // RL8
   };

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         out_q <= `LPCR_OUT_RESET;
      else
         out_q <= out_d;
   end

   assign {clock_lane_protocol_select, clock_lane_hs_termination_enable, clock_lane_hs_receiver_enable,
           clock_lane_hs_receiver_wakeup, data_lane_protocol_select, data_lane_hs_termination_enable,
           data_lane_hs_receiver_enable, data_lane_hs_receiver_wakeup, data_lane_enable, data_lane_pn_swap} = out_q;
   assign sda_o = 1'b0;
   assign sda_oe = oe_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   proto_write_only_a: assert property ($changed(clock_lane_protocol_select) |-> $past(wr_clk_mode, 2)) // RL1
      else $error("clock lane protocol changed without a write");
   clk_term_gate_a: assert property (clock_lane_hs_termination_enable |-> !clock_lane_protocol_select) // RL2
      else $error("clock termination active in CSI");
   dl_term_gate_a: assert property (data_lane_hs_termination_enable |-> !data_lane_protocol_select) // RL2
      else $error("data termination active in CSI");
   rx_enable_gate_a: assert property (wr_dl_mode && sh_q[`LPCR_DL_RXEN_BIT] && !sh_q[`LPCR_DL_PROTO_BIT] |-> ##2 data_lane_hs_receiver_enable) // RL3
      else $error("data receiver enable missing after CCP write");
   wake_gate_a: assert property (clock_lane_hs_receiver_wakeup |-> !clock_lane_protocol_select) // RL4
      else $error("clock wakeup active in CSI");
   ulp_status_a: assert property (clk_csi && ulp_f && ptr_q == `LPCR_OFF_CLK_STATUS |-> rd_ptr[1]) // RL5
      else $error("ulp status not shown");
   stop_status_a: assert property (!clk_csi && ptr_q == `LPCR_OFF_CLK_STATUS |-> rd_ptr == 8'h00) // RL6
      else $error("status not masked in CCP");
   lane_enable_a: assert property (wr_dl_gen |-> ##2 data_lane_enable == $past(sh_q[`LPCR_DL_EN_BIT], 2)) // RL7
      else $error("lane enable did not follow write");
   pin_swap_a: assert property (wr_dl_gen |-> ##2 data_lane_pn_swap == !$past(sh_q[`LPCR_DL_SWAP_N_BIT], 2)) // RL8
      else $error("swap polarity wrong");
   reserved_zero_a: assert property ((clk_mode_q & ~`LPCR_CLK_MODE_MASK) == 8'h00 && dl_mode_q[7:4] == 4'h0) // RL9
      else $error("reserved bits stored");
   status_ro_a: assert property (wr_fire && ptr_q == `LPCR_OFF_CLK_STATUS |=> $stable(clk_mode_q)) // RL10
      else $error("status write changed a register");
   sda_drive_a: assert property (sda_oe |-> st_q != lpcr_pkg::LPCR_IDLE && st_q != lpcr_pkg::LPCR_ADDR)
      else $error("sda driven outside ack or read");

   write_seen_c: cover property (wr_clk_mode);
   read_seen_c: cover property (st_q == lpcr_pkg::LPCR_TX && scl_fall);
   addr_miss_c: cover property (st_q == lpcr_pkg::LPCR_ADDR ##1 st_q == lpcr_pkg::LPCR_IDLE);
   lane_on_c: cover property ($rose(data_lane_enable));
endmodule
`default_nettype wire

// ===== hw/lpcr_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module lpcr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] q_q;
   wire [W-1:0] agree = ~(s2_q ^ s3_q);
   // A change only counts once the last two stages agree
   wire [W-1:0] q_d = (agree & s3_q) | (~agree & q_q);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         q_q <= RST;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q <= q_d;
      end
   end

   assign q = q_q;
endmodule
`default_nettype wire

// ===== shared/lpcr_consts.svh
// Offsets, field positions, masks and reset values of the lane control registers
`ifndef LPCR_CONSTS_SVH
`define LPCR_CONSTS_SVH

`define LPCR_OFF_CLK_STATUS 8'h01
`define LPCR_OFF_CLK_MODE 8'h04
`define LPCR_OFF_DL_GEN 8'h05
`define LPCR_OFF_DL_MODE 8'h06

`define LPCR_CLK_MODE_MASK 8'h1e
`define LPCR_DL_GEN_MASK 8'h03
`define LPCR_DL_MODE_MASK 8'h0f
`define LPCR_CTRL_RESET 8'h00

`define LPCR_CLK_TERM_BIT 4
`define LPCR_CLK_RXEN_BIT 3
`define LPCR_CLK_WAKE_BIT 2
`define LPCR_CLK_PROTO_BIT 1
`define LPCR_DL_TERM_BIT 3
`define LPCR_DL_RXEN_BIT 2
`define LPCR_DL_WAKE_BIT 1
`define LPCR_DL_PROTO_BIT 0
`define LPCR_DL_SWAP_N_BIT 1
`define LPCR_DL_EN_BIT 0
`define LPCR_ST_ULP_BIT 1
`define LPCR_ST_STOP_BIT 0

// Bus address; the value is arbitrary
`define LPCR_DEV_ADDR 7'h2a
`define LPCR_BITS_PER_BYTE 4'h8
`define LPCR_TX_ACK_CNT 4'h9
`define LPCR_OUT_RESET 10'h001

`endif

// ===== shared/lpcr_pkg.sv
// Types shared by the lane control register block
`default_nettype none
package lpcr_pkg;
   typedef enum logic [5:0] {
      LPCR_IDLE = 6'h01,
      LPCR_ADDR = 6'h02,
      LPCR_ACK_ADDR = 6'h04,
      LPCR_RX = 6'h08,
      LPCR_ACK_RX = 6'h10,
      LPCR_TX = 6'h20
   } lpcr_state_t;
   typedef logic [7:0] lpcr_byte_t;
endpackage
`default_nettype wire
